// ==== src/acc_access_map.svh ====
// Purpose: offsets, field layout, reset values for the accumulator unit
// Assumes: 32-bit Wishbone words, byte addresses
// Notes:   definitions only
`ifndef ACC_ACCESS_MAP_SVH
`define ACC_ACCESS_MAP_SVH

`define CTRL_OFFSET    8'h00
`define RESULT_OFFSET  8'h04
`define STATUS_OFFSET  8'h08
`define CTRL_RESET     32'h0000_0000
`define CTRL_VALID     32'h0fff_7fff
`define MASK_WIDTH     6
`define CURSOR_WIDTH   6
`define CURSOR_STEP    6'h20
`define PULL_FAIL_BIT  14
`define Q31_MAX        32'h7fff_ffff
// Field selected by each mask bit
`define FIELD_MASK_0   32'h0000_003f
`define FIELD_MASK_1   32'h0000_1f80
`define FIELD_MASK_2   32'h0000_2000
`define FIELD_MASK_3   32'h00ff_0000
`define FIELD_MASK_4   32'h0f00_0000
`define FIELD_MASK_5   32'h0000_4000

`endif

// ==== src/acc_access_pkg.sv ====
// Purpose: types shared by the accumulator access unit and its users
// Assumes: operations arrive one per cycle from the pipeline
// Notes:   operation codes are local to this unit
package acc_access_pkg;

  typedef enum logic [4:0] {
    extract_word_var           = 5'h00,
    extract_word_var_round     = 5'h01,
    extract_word_var_round_sat = 5'h02,
    field_pull                 = 5'h03,
    field_pull_var             = 5'h04,
    field_pull_advance         = 5'h05,
    field_pull_advance_var     = 5'h06,
    wide_shift                 = 5'h07,
    wide_shift_var             = 5'h08,
    insert_word_advance        = 5'h09,
    read_upper_half            = 5'h0a,
    read_bottom_half           = 5'h0b,
    write_upper_half           = 5'h0c,
    write_bottom_half          = 5'h0d,
    masked_ctrl_write          = 5'h0e,
    masked_ctrl_read           = 5'h0f,
    branch_cursor_ge_thirtytwo = 5'h10,
    branch_cursor_ge_compact   = 5'h11
  } op_code_type;

  typedef struct packed {
    logic        valid;
    op_code_type op;
    logic [1:0]  acc_sel;
    logic [31:0] src_gpr_a;
    logic [31:0] src_gpr_b;
    logic [5:0]  imm;
    logic [5:0]  mask;
  } op_request_type;

  typedef struct packed {
    logic        valid;
    logic        gpr_we;
    logic [31:0] gpr_data;
    logic        branch_taken;
  } op_result_type;

endpackage

// ==== src/dsp_accumulator_access.sv ====
// Purpose: accumulator and control-register access datapath
// Assumes: one operation per cycle, same clock as the pipeline
// Notes:   results appear one cycle after the request
//
// Added by the designer: the address map and register access over Wishbone.
`include "acc_access_map.svh"
`timescale 1ns/1ns
`default_nettype none

module dsp_accumulator_access
  import acc_access_pkg::*;
#(
  parameter int ACC_COUNT = 4
) (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           reset,
  // Pipeline side
  input  wire op_request_type req,
  output var  op_result_type  result,
  // Wishbone slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic                wb_ack_o,
  output logic [31:0]         wb_dat_o
);

  localparam logic [31:0] FIELD_TABLE [`MASK_WIDTH] = '{
    `FIELD_MASK_0, `FIELD_MASK_1, `FIELD_MASK_2,
    `FIELD_MASK_3, `FIELD_MASK_4, `FIELD_MASK_5
  };

  logic [63:0]              acc_reg  [ACC_COUNT];
  logic [63:0]              acc_next [ACC_COUNT];
  logic [31:0]              ctrl_reg;
  logic [31:0]              ctrl_next;
  op_result_type            result_reg;
  op_result_type            result_next;
  logic [31:0]              last_reg;
  logic [31:0]              last_next;
  logic                     ack_reg;
  logic                     ack_next;
  logic [31:0]              rdata_reg;
  logic [31:0]              rdata_next;

  logic [63:0]              sel_acc;
  logic [`CURSOR_WIDTH-1:0] pos;
  logic                     bus_take;
  logic                     bus_write;
  logic [31:0]              lane_mask;

  assign sel_acc  = acc_reg[req.acc_sel];
  assign pos      = ctrl_reg[`CURSOR_WIDTH-1:0];

  // Word extract
  logic [4:0]  xsh;
  logic [63:0] xshift;
  logic [63:0] xpre;
  logic [64:0] xsum;
  logic [31:0] xround;
  logic        xovf;

  assign xsh    = req.src_gpr_a[4:0];
  assign xshift = sel_acc >> xsh;
  assign xpre   = sel_acc >> (xsh - 5'h01);
  assign xsum   = {1'b0, xpre} + 65'h1;
  assign xround = (xsh == 5'h00) ? xshift[31:0] : xsum[32:1];
  // Overflow when a positive word turns negative through the carry
  assign xovf   = (xsh != 5'h00) && !xshift[31] && xsum[32];

  // Field pull
  logic                     pull_imm;
  logic [4:0]               psize;
  logic [`CURSOR_WIDTH-1:0] plow;
  logic                     punder;
  logic [63:0]              pshift;
  logic [31:0]              pleft;
  logic [31:0]              pull_val;
  logic [`CURSOR_WIDTH-1:0] pos_after;

  assign pull_imm  = (req.op == field_pull) || (req.op == field_pull_advance);
  assign psize     = pull_imm ? req.imm[4:0] : req.src_gpr_a[4:0];
  assign plow      = pos - {1'b0, psize};
  assign punder    = pos < {1'b0, psize};
  assign pshift    = sel_acc >> plow;
  assign pleft     = pshift[31:0] << (5'h1f - psize);
  assign pull_val  = $unsigned($signed(pleft) >>> (5'h1f - psize));
  assign pos_after = plow - 6'h01;

  // Wide shift
  logic [5:0]  samt;
  logic [6:0]  smag;
  logic [63:0] sval;

  assign samt = (req.op == wide_shift) ? req.imm : req.src_gpr_a[5:0];
  assign smag = 7'h00 - {samt[5], samt};
  assign sval = samt[5] ? (sel_acc >> smag) : (sel_acc << samt[4:0]);

  // Field mask built one mask bit at a time
  logic [31:0] fchain [`MASK_WIDTH+1];
  logic [31:0] fmask;

  assign fchain[0] = 32'h0000_0000;
  for (genvar i = 0; i < `MASK_WIDTH; i++) begin : g_field
    assign fchain[i+1] = fchain[i] | (req.mask[i] ? FIELD_TABLE[i] : 32'h0000_0000);
  end
  assign fmask = fchain[`MASK_WIDTH];

  // Bus decode
  assign bus_take  = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_write = bus_take && wb_we_i && (wb_adr_i == `CTRL_OFFSET);
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  always_comb begin
    acc_next    = acc_reg;
    ctrl_next   = ctrl_reg;
    last_next   = last_reg;
    result_next = '0;
    // A pipeline update of the same field lands after the bus write
    if (bus_write) begin
      ctrl_next = (ctrl_reg & ~lane_mask) | (wb_dat_i & lane_mask & `CTRL_VALID);
    end
    if (req.valid) begin
      result_next.valid = 1'b1;
      unique case (req.op)
        extract_word_var, extract_word_var_round,
        extract_word_var_round_sat: begin
          result_next.gpr_we = 1'b1;
          if (req.op == extract_word_var) begin
            result_next.gpr_data = xshift[31:0];
          end else if (req.op == extract_word_var_round_sat && xovf) begin
            result_next.gpr_data = `Q31_MAX;
          end else begin
            result_next.gpr_data = xround;
          end
        end
        field_pull, field_pull_var: begin
          result_next.gpr_we   = 1'b1;
          result_next.gpr_data = pull_val;
        end
        field_pull_advance, field_pull_advance_var: begin
          result_next.gpr_we   = 1'b1;
          result_next.gpr_data = pull_val;
          // Too few bits left: flag it and keep the cursor
          ctrl_next[`PULL_FAIL_BIT] = punder;
          if (!punder) begin
            ctrl_next[`CURSOR_WIDTH-1:0] = pos_after;
          end
        end
        wide_shift, wide_shift_var: begin
          acc_next[req.acc_sel] = sval;
        end
        insert_word_advance: begin
          acc_next[req.acc_sel] = {sel_acc[31:0], req.src_gpr_a};
          ctrl_next[`CURSOR_WIDTH-1:0] = pos + `CURSOR_STEP;
        end
        read_upper_half: begin
          result_next.gpr_we   = 1'b1;
          result_next.gpr_data = sel_acc[63:32];
        end
        read_bottom_half: begin
          result_next.gpr_we   = 1'b1;
          result_next.gpr_data = sel_acc[31:0];
        end
        write_upper_half: begin
          acc_next[req.acc_sel][63:32] = req.src_gpr_a;
        end
        write_bottom_half: begin
          acc_next[req.acc_sel][31:0] = req.src_gpr_a;
        end
        masked_ctrl_write: begin
          ctrl_next = (ctrl_next & ~fmask) | (req.src_gpr_a & fmask);
        end
        masked_ctrl_read: begin
          result_next.gpr_we   = 1'b1;
          result_next.gpr_data = (req.src_gpr_b & ~fmask) | (ctrl_reg & fmask);
        end
        branch_cursor_ge_thirtytwo, branch_cursor_ge_compact: begin
          result_next.branch_taken = (pos >= `CURSOR_STEP);
        end
        default: begin
          result_next.valid = 1'b0;
        end
      endcase
      if (result_next.gpr_we) begin
        last_next = result_next.gpr_data;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < ACC_COUNT; k++) begin
        acc_reg[k] <= 64'h0;
      end
      ctrl_reg   <= `CTRL_RESET;
      result_reg <= '0;
      last_reg   <= 32'h0000_0000;
    end else begin
      acc_reg    <= acc_next;
      ctrl_reg   <= ctrl_next;
      result_reg <= result_next;
      last_reg   <= last_next;
    end
  end

  assign result = result_reg;

  // Bus slave: one wait state, unmapped reads return zero
  always_comb begin
    ack_next   = bus_take;
    rdata_next = rdata_reg;
    if (bus_take) begin
      unique case (wb_adr_i)
        `CTRL_OFFSET:   rdata_next = ctrl_reg;
        `RESULT_OFFSET: rdata_next = last_reg;
        `STATUS_OFFSET: rdata_next = {31'h0, pos >= `CURSOR_STEP};
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_word_plain_value: assert property (
    req.valid && req.op == extract_word_var
    |=> result.gpr_we && result.gpr_data == 32'($past(sel_acc) >> $past(xsh)))
    else $error("plain word extract wrong");

  a_word_round_add: assert property (
    req.valid && req.op == extract_word_var_round && xsh != 5'h00
    |=> result.gpr_data
        == 32'((65'($past(sel_acc) >> ($past(xsh) - 5'h01)) + 65'h1) >> 1))
    else $error("rounded word extract wrong");

  a_word_sat_clamp: assert property (
    req.valid && req.op == extract_word_var_round_sat && xovf
    |=> result.gpr_data == `Q31_MAX)
    else $error("saturation did not clamp");

  a_pull_cursor_step: assert property (
    req.valid && req.op inside {field_pull_advance, field_pull_advance_var}
    && !punder && !bus_write
    |=> pos == $past(pos) - {1'b0, $past(psize)} - 6'h01)
    else $error("cursor not reduced by size plus one");

  a_insert_advance_moves: assert property (
    req.valid && req.op == insert_word_advance && !bus_write
    |=> pos == $past(pos) + `CURSOR_STEP
        && acc_reg[$past(req.acc_sel)] == {$past(sel_acc[31:0]), $past(req.src_gpr_a)})
    else $error("insert advance wrong");

  a_upper_half_write: assert property (
    req.valid && req.op == write_upper_half
    |=> acc_reg[$past(req.acc_sel)][63:32] == $past(req.src_gpr_a))
    else $error("upper half not written");

  a_masked_read_merge: assert property (
    req.valid && req.op == masked_ctrl_read
    |=> result.gpr_data == (($past(req.src_gpr_b) & ~$past(fmask))
        | ($past(ctrl_reg) & $past(fmask))))
    else $error("masked read merge wrong");

  a_branch_cursor_test: assert property (
    req.valid && req.op inside {branch_cursor_ge_thirtytwo, branch_cursor_ge_compact}
    |=> result.valid && result.branch_taken == ($past(pos) >= `CURSOR_STEP))
    else $error("cursor branch decision wrong");

  a_shift_only_acc: assert property (
    req.valid && req.op inside {wide_shift, wide_shift_var} && !bus_write
    |=> !result.gpr_we && $stable(ctrl_reg))
    else $error("wide shift touched other state");

  a_bus_ack_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a one-cycle answer");

  c_sat_clamp:   cover property (req.valid && req.op == extract_word_var_round_sat && xovf);
  c_pull_under:  cover property (req.valid && req.op == field_pull_advance && punder);
  c_shift_right: cover property (req.valid && req.op == wide_shift_var && samt[5]);
  c_branch_take: cover property (result.branch_taken);

endmodule // dsp_accumulator_access

`default_nettype wire

// ==== bench/pipe_model.sv ====
// Purpose: pipeline sink that retires the accumulator unit's results
// Assumes: at most one result per cycle
// Notes:   keeps the last register write and a count of answers
`timescale 1ns/1ns
`default_nettype none

module pipe_model
  import acc_access_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  // Result from the unit
  input  wire op_result_type result,
  // Retired state
  output var  logic [31:0]   last_gpr,
  output var  int            answers
);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      last_gpr <= 32'h0;
      answers  <= 0;
    end else if (result.valid) begin
      answers <= answers + 1;
      if (result.gpr_we) begin
        last_gpr <= result.gpr_data;
      end
    end
  end
endmodule // pipe_model
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the accumulator access unit
// Assumes: one-cycle result latency, registered Wishbone ack
// Notes:   random op mix checked against a queue-free integer model
`include "acc_access_map.svh"
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module tb;
  import acc_access_pkg::*;
  logic           clock;
  logic           reset;
  op_request_type req;
  op_result_type  result;
  logic           wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]     wb_adr;
  logic [3:0]     wb_sel;
  logic [31:0]    wb_wdat, wb_rdat, q, seed, ctrl, last_wr, r;
  logic [31:0]    last_gpr;
  logic [63:0]    acc [4];
  logic [31:0]    fm [6] = '{`FIELD_MASK_0, `FIELD_MASK_1, `FIELD_MASK_2,
                             `FIELD_MASK_3, `FIELD_MASK_4, `FIELD_MASK_5};
  int             answers, fails, num_checks, nops, cycles;

  dsp_accumulator_access #(.ACC_COUNT(4)) dut (.clock(clock), .reset(reset), .req(req),
    .result(result), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_ack_o(wb_ack),
    .wb_dat_o(wb_rdat));
  pipe_model pipe (.clock(clock), .reset(reset), .result(result), .last_gpr(last_gpr),
    .answers(answers));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      stop_test();
    end
  end

  // Holds the request until ack is sampled high, as the bus requires
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    input logic [3:0] sl, output logic [31:0] rd);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= ad;
    wb_wdat <= d;
    wb_sel <= sl;
    do @(posedge clock); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (w && ad == `CTRL_OFFSET) begin
      for (int i = 0; i < 4; i++) if (sl[i]) ctrl[8*i+:8] = d[8*i+:8];
      ctrl = ctrl & `CTRL_VALID;
    end
  endtask

  task automatic run(input op_code_type op, input logic [1:0] s, input logic [31:0] a,
                     input logic [31:0] b, input logic [5:0] imm, input logic [5:0] msk);
    logic [64:0] t;
    logic [31:0] e;
    logic [5:0]  pos, sz, amt;
    logic        we, br, ok, legal;
    e = 32'h0;
    we = 1'b0;
    br = 1'b0;
    ok = 1'b1;
    pos = ctrl[5:0];
    legal = op <= branch_cursor_ge_compact;
    case (op)
      extract_word_var, extract_word_var_round, extract_word_var_round_sat: begin
        we = 1'b1;
        e = acc[s] >> a[4:0];
        if (op != extract_word_var && a[4:0] != 5'h0) begin
          t = (({1'b0, acc[s]} >> (a[4:0] - 5'h1)) + 65'h1) >> 1;
          if (op == extract_word_var_round_sat && !e[31] && t[31]) e = `Q31_MAX;
          else e = t[31:0];
        end
      end
      field_pull, field_pull_var, field_pull_advance, field_pull_advance_var: begin
        we = 1'b1;
        sz = (op == field_pull || op == field_pull_advance) ? {1'b0, imm[4:0]} : {1'b0, a[4:0]};
        ok = pos >= sz;
        e = acc[s] >> (pos - sz);
        e = $signed(e << (31 - sz)) >>> (31 - sz);
        if (op == field_pull_advance || op == field_pull_advance_var) begin
          ctrl[`PULL_FAIL_BIT] = !ok;
          if (ok) ctrl[5:0] = pos - sz - 6'h1;
        end
      end
      wide_shift, wide_shift_var: begin
        amt = (op == wide_shift) ? imm : a[5:0];
        acc[s] = amt[5] ? acc[s] >> (-amt) : acc[s] << amt;
      end
      insert_word_advance: begin
        acc[s] = {acc[s][31:0], a};
        ctrl[5:0] = pos + `CURSOR_STEP;
      end
      read_upper_half: begin
        we = 1'b1;
        e = acc[s][63:32];
      end
      read_bottom_half: begin
        we = 1'b1;
        e = acc[s][31:0];
      end
      write_upper_half: acc[s][63:32] = a;
      write_bottom_half: acc[s][31:0] = a;
      masked_ctrl_write: begin
        for (int i = 0; i < 6; i++) begin
          if (msk[i]) ctrl = (ctrl & ~fm[i]) | (a & fm[i]);
        end
      end
      masked_ctrl_read: begin
        we = 1'b1;
        e = b;
        for (int i = 0; i < 6; i++) if (msk[i]) e = (e & ~fm[i]) | (ctrl & fm[i]);
      end
      branch_cursor_ge_thirtytwo, branch_cursor_ge_compact: br = pos[5];
      default: ;
    endcase
    if (we && ok) last_wr = e;
    if (legal) nops++;
    @(posedge clock);
    req <= '{1'b1, op, s, a, b, imm, msk};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    `CHK("valid", legal, result.valid)
    if (legal) begin
      `CHK("gpr_we", we, result.gpr_we)
      `CHK("branch", br, result.branch_taken)
      if (we && ok) `CHK("gpr_data", e, result.gpr_data)
    end
  endtask

  initial begin
    reset = 1'b1;
    req = '0;
    seed = 32'h5fd1;
    ctrl = `CTRL_RESET;
    last_wr = 32'h0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h0;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    acc = '{default: 64'h0};
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    wb(1'b0, `CTRL_OFFSET, 32'h0, 4'hf, q);
    `CHK("ctrl_reset", `CTRL_RESET, q)
    wb(1'b1, `CTRL_OFFSET, rnd(), 4'hf, q);
    wb(1'b1, `CTRL_OFFSET, rnd(), 4'h5, q);
    wb(1'b1, `RESULT_OFFSET, rnd(), 4'hf, q);
    wb(1'b0, `CTRL_OFFSET, 32'h0, 4'hf, q);
    `CHK("ctrl_bus", ctrl, q)
    wb(1'b0, 8'h0c, 32'h0, 4'hf, q);
    `CHK("unmapped", 32'h0, q)
    $display("bus test done");
    // Rounding carry into bit 31 must clamp only in the saturating form
    run(write_upper_half, 2'h0, 32'h0, 32'h0, 6'h0, 6'h0);
    run(write_bottom_half, 2'h0, 32'hffff_ffff, 32'h0, 6'h0, 6'h0);
    for (int k = 0; k < 3; k++) begin
      run(op_code_type'(5'(k)), 2'h0, 32'h1, 32'h0, 6'h0, 6'h0);
    end
    $display("saturation test done");
    repeat (400) begin
      r = rnd();
      run(op_code_type'(r[4:0] % 5'd20), r[6:5], rnd(), rnd(), r[12:7], r[18:13]);
      if (r[31:29] == 3'h0) wb(1'b1, `CTRL_OFFSET, rnd(), r[22:19], q);
    end
    wb(1'b0, `CTRL_OFFSET, 32'h0, 4'hf, q);
    `CHK("ctrl_after", ctrl, q)
    $display("random test done");
    run(read_upper_half, 2'h1, 32'h0, 32'h0, 6'h0, 6'h0);
    wb(1'b0, `RESULT_OFFSET, 32'h0, 4'hf, q);
    `CHK("result_reg", last_wr, q)
    `CHK("retired", last_wr, last_gpr)
    wb(1'b0, `STATUS_OFFSET, 32'h0, 4'hf, q);
    `CHK("status", {31'h0, ctrl[5]}, q)
    `CHK("answers", nops, answers)
    $display("final test done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
